// *** ebp_pkg_dband.sv ***
/*
 * Shared package of the bridge output modulator and its dead-band stage.
 * The package holds register offsets, field positions, reset values, timing
 * counts and the carrier types; the dead-band module delays each rising edge
 * of one output by the programmed number of instruction cycles.
 * Assumes a single clock at the oscillator rate, a synchronous active-high
 * reset and a clock enable that freezes all state while low.
 */
`timescale 1ns/1ps

package ebp_pkg;

   // ----------------------------------------------------------------------
   // Register offsets (byte addresses, one 32-bit word each)
   // ----------------------------------------------------------------------
   localparam logic [11:0] EBP_OFS_CTRL = 12'h000;
   localparam logic [11:0] EBP_OFS_DUTY = 12'h004;
   localparam logic [11:0] EBP_OFS_PERIOD = 12'h008;
   localparam logic [11:0] EBP_OFS_TCTRL = 12'h00C;
   localparam logic [11:0] EBP_OFS_DBAND = 12'h010;
   localparam logic [11:0] EBP_OFS_STEER = 12'h014;
   localparam logic [11:0] EBP_OFS_DIR = 12'h018;
   localparam logic [11:0] EBP_OFS_STATUS = 12'h01C;

   // ----------------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------------
   localparam int EBP_CTRL_MODE_LSB = 6;
   localparam int EBP_CTRL_DLOW_LSB = 4;
   localparam int EBP_CTRL_SEL_LSB = 2;
   localparam int EBP_CTRL_POL_AC = 1;
   localparam int EBP_CTRL_POL_BD = 0;
   localparam int EBP_TCTRL_ON = 2;
   localparam int EBP_TCTRL_PS_LSB = 0;
   localparam logic [1:0] EBP_SEL_PWM = 2'b11;

   // ----------------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------------
   localparam logic [7:0] EBP_CTRL_RST = 8'h00;
   localparam logic [7:0] EBP_DUTY_RST = 8'h00;
   localparam logic [7:0] EBP_PERIOD_RST = 8'hFF;
   localparam logic [7:0] EBP_TCTRL_RST = 8'h00;
   localparam logic [7:0] EBP_DBAND_RST = 8'h00;
   localparam logic [3:0] EBP_STEER_RST = 4'h1;
   localparam logic [3:0] EBP_DIR_RST = 4'hF;

   // ----------------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------------
   localparam int EBP_CLK_PERIOD_NS = 20;
   localparam int EBP_TOSC_NS = 20;
   localparam int EBP_OSC_PER_TCY = 4;
   localparam int EBP_TCY_NS = EBP_OSC_PER_TCY * EBP_TOSC_NS;
   localparam logic [8:0] EBP_TCY_CLKS = 9'((EBP_TCY_NS + EBP_CLK_PERIOD_NS - 1)
                                            / EBP_CLK_PERIOD_NS);
   localparam logic [5:0] EBP_PRESC_WRAP_1 = 6'h03;
   localparam logic [5:0] EBP_PRESC_WRAP_4 = 6'h0F;
   localparam logic [5:0] EBP_PRESC_WRAP_16 = 6'h3F;

   // ----------------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      EBP_SINGLE = 2'b00,
      EBP_FULL_FWD = 2'b01,
      EBP_HALF = 2'b10,
      EBP_FULL_REV = 2'b11
   } ebp_mode_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } ebp_apb_req_t;

   typedef struct packed {
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
   } ebp_apb_rsp_t;

   typedef struct packed {
      logic bridge_output_d;
      logic bridge_output_c;
      logic bridge_output_b;
      logic bridge_output_a;
   } ebp_pins_t;

   typedef struct packed {
      logic [8:0] cnt;
   } ebp_dband_state_t;

   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] duty_hi;
      logic [7:0] period;
      logic [7:0] tctrl;
      logic [7:0] dband;
      logic [3:0] steer;
      logic [3:0] dir;
      logic [9:0] duty_act;
      logic [6:0] db_act;
      logic [7:0] tmr;
      logic [5:0] presc;
      logic running;
      logic [3:0] pin_lvl;
      logic [3:0] pin_own;
      logic [3:0] pin_oe;
      logic [31:0] prdata;
      logic rd_ok;
   } ebp_state_t;

endpackage

module ebp_dband
   import ebp_pkg::*;
(
   input wire logic clk_in,       // Oscillator clock.
   input wire logic reset_in,     // Synchronous reset, active high.
   input wire logic ce_in,        // Clock enable, freezes state when low.
   input wire logic hold_in,      // Sleep hold, freezes the count.
   input wire logic level_in,     // Undelayed active-level request.
   input wire logic [6:0] delay_in, // Delay in instruction cycles.
   output logic level_out         // Request with its rising edge delayed.
);

   ebp_dband_state_t state_reg;
   ebp_dband_state_t state_next;
   logic [8:0] target;

   // ----------------------------------------------------------------------
   // Delay counter
   // ----------------------------------------------------------------------
   // The counter saturates instead of wrapping so a long active phase never
   // drops the output again part way through.
   assign target = 9'(delay_in) * EBP_TCY_CLKS;
   assign level_out = level_in && (state_reg.cnt >= target);

   always_comb begin
      state_next = state_reg;
      if (!hold_in) begin
         if (!level_in) begin
            state_next.cnt = 9'h000;
         end else if (state_reg.cnt != 9'h1FF) begin
            state_next.cnt = state_reg.cnt + 9'h001;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         state_reg <= '0;
      end else if (ce_in) begin
         state_reg <= state_next;
      end
   end

   a_dband_wait: assert property (@(posedge clk_in) disable iff (reset_in)
      (level_out && !$past(level_out) && delay_in != 7'h00) |-> (state_reg.cnt == target))
      else $error("dead-band output rose before its delay had elapsed");

endmodule

// *** ebp_bridge_pwm.sv ***
/*
 * Bridge output modulator: 8-bit timer with 2-bit fine extension, 10-bit
 * duty compare, single, half-bridge and full-bridge output modes, output
 * polarity, dead-band delay and pin direction control, behind an APB slave.
 * Assumes the APB master and the sleep request run on clk_in, and that the
 * pad logic combines the level and enable outputs with alternate functions.
 */
// Behaviour
// - Drive up to four output pins with a modulated waveform of 10-bit resolution.
// - Mode field: 00 single, 10 half-bridge, 01 full forward, 11 full reverse.
// - Control bits 1 and 0 select active-high or active-low levels for pairs A/C and B/D.
// - Writing the control register to zero releases the output pins.
// - Pins unused by the selected mode stay free for other functions.
// - After enabling, wait for the next period boundary; no partial pulse.
// - Time base is the 8-bit timer count with two fine bits appended.
// - Half-bridge-only builds provide no outputs C and D.
// - In single mode each output is enabled only by its steering bit.
// - Period is four oscillator periods times period plus one times prescale.
// - Pulse width is 10-bit duty times oscillator period times prescale.
// - Dead-band delay is four oscillator periods times the 7-bit field.
// - Half-bridge delays each change to active by the programmed cycles.
// - A delay longer than the active time keeps that output inactive.
// - Half-bridge drives the waveform on A and its complement on B.
// - Both full-bridge modes use all four output pins.
// - Full forward: A active, D modulated, B and C inactive.
// - Full reverse: C active, B modulated, A and D inactive.
// - Timer equal to period register ends the period; next starts there.
// - Timer prescale factors are 1, 4 and 16.
// - Sleep stops the timer, keeps state and pin values, resumes after.
// - Reset returns registers to reset values and pins to input mode.
`timescale 1ns/1ps

module ebp_bridge_pwm
   import ebp_pkg::*;
#(
   parameter bit HALF_BRIDGE_ONLY = 1'b0 // Build without outputs C and D.
)
(
   input wire logic clk_in,         // Oscillator clock, 50 MHz.
   input wire logic reset_in,       // Synchronous reset, active high.
   input wire logic ce_in,          // Clock enable, freezes all state when low.
   input wire logic sleep_in,       // Sleep request, same clock domain.
   input wire ebp_apb_req_t apb_in, // APB request signals.
   output ebp_apb_rsp_t apb_out,    // APB answer signals.
   output ebp_pins_t pin_level_out, // Level driven on each output pin.
   output ebp_pins_t pin_oe_out,    // High while the pin is driven.
   output ebp_pins_t pin_owned_out  // High while the modulator owns the pin.
);

   ebp_state_t state_reg;
   ebp_state_t state_next;

   // ----------------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------------
   function automatic logic [5:0] presc_wrap(input logic [1:0] ps);
      case (ps)
         2'b00: presc_wrap = EBP_PRESC_WRAP_1;
         2'b01: presc_wrap = EBP_PRESC_WRAP_4;
         default: presc_wrap = EBP_PRESC_WRAP_16;
      endcase
   endfunction

   // Fine bits are the prescaler bits just below the timer increment, so
   // the 10-bit time base always advances once per oscillator times prescale.
   function automatic logic [1:0] fine_bits(input logic [1:0] ps, input logic [5:0] p);
      case (ps)
         2'b00: fine_bits = p[1:0];
         2'b01: fine_bits = p[3:2];
         default: fine_bits = p[5:4];
      endcase
   endfunction

   function automatic logic is_mapped(input logic [11:0] addr);
      is_mapped = (addr == EBP_OFS_CTRL) || (addr == EBP_OFS_DUTY) ||
                  (addr == EBP_OFS_PERIOD) || (addr == EBP_OFS_TCTRL) ||
                  (addr == EBP_OFS_DBAND) || (addr == EBP_OFS_STEER) ||
                  (addr == EBP_OFS_DIR) || (addr == EBP_OFS_STATUS);
   endfunction

   function automatic logic [3:0] apply_pol(input logic [3:0] act, input logic ac_low,
                                            input logic bd_low);
      apply_pol = act ^ {bd_low, ac_low, bd_low, ac_low};
   endfunction

   // ----------------------------------------------------------------------
   // Decoded control
   // ----------------------------------------------------------------------
   ebp_mode_t mode_w;
   logic pwm_sel;
   logic tmr_on;
   logic [1:0] ps_w;
   logic [1:0] fine_w;
   logic [9:0] timebase;
   logic wrap_w;
   logic boundary;
   logic advance;
   logic active_w;
   logic db_a;
   logic db_b;
   logic apb_done;

   assign mode_w = ebp_mode_t'(state_reg.ctrl[EBP_CTRL_MODE_LSB +: 2]);
   assign pwm_sel = state_reg.ctrl[EBP_CTRL_SEL_LSB +: 2] == EBP_SEL_PWM;
   assign tmr_on = state_reg.tctrl[EBP_TCTRL_ON];
   assign ps_w = state_reg.tctrl[EBP_TCTRL_PS_LSB +: 2];
   assign fine_w = fine_bits(ps_w, state_reg.presc);
   assign timebase = {state_reg.tmr, fine_w};
   assign wrap_w = state_reg.presc == presc_wrap(ps_w);
   assign boundary = tmr_on && wrap_w && (state_reg.tmr == state_reg.period);
   assign advance = !sleep_in;
   assign active_w = state_reg.running && (timebase < state_reg.duty_act);
   assign apb_done = apb_in.psel && apb_in.penable && apb_out.pready;

   // ----------------------------------------------------------------------
   // Dead-band stages for the half-bridge pair
   // ----------------------------------------------------------------------
   ebp_dband u_dband_a (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .ce_in(ce_in),
      .hold_in(sleep_in),
      .level_in(active_w),
      .delay_in(state_reg.db_act),
      .level_out(db_a)
   );

   ebp_dband u_dband_b (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .ce_in(ce_in),
      .hold_in(sleep_in),
      .level_in(state_reg.running && !active_w),
      .delay_in(state_reg.db_act),
      .level_out(db_b)
   );

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb begin
      logic [3:0] act;
      logic [3:0] used;
      logic [3:0] own;
      act = 4'h0;
      used = 4'h0;
      own = 4'h0;
      state_next = state_reg;

      // Register writes take effect only at the completing access edge.
      if (apb_done && apb_in.pwrite) begin
         unique case (apb_in.paddr)
            EBP_OFS_CTRL: state_next.ctrl = apb_in.pwdata[7:0];
            EBP_OFS_DUTY: state_next.duty_hi = apb_in.pwdata[7:0];
            EBP_OFS_PERIOD: state_next.period = apb_in.pwdata[7:0];
            EBP_OFS_TCTRL: state_next.tctrl = {5'h00, apb_in.pwdata[2:0]};
            EBP_OFS_DBAND: state_next.dband = {1'b0, apb_in.pwdata[6:0]};
            EBP_OFS_STEER: state_next.steer = apb_in.pwdata[3:0];
            EBP_OFS_DIR: state_next.dir = apb_in.pwdata[3:0];
            default: ;
         endcase
      end

      // Read data is captured in the setup cycle so the access phase can end
      // without wait states while prdata still comes from a flip-flop.
      if (apb_done) begin
         state_next.rd_ok = 1'b0;
      end else if (apb_in.psel) begin
         state_next.rd_ok = 1'b1;
         unique case (apb_in.paddr)
            EBP_OFS_CTRL: state_next.prdata = {24'h000000, state_reg.ctrl};
            EBP_OFS_DUTY: state_next.prdata = {24'h000000, state_reg.duty_hi};
            EBP_OFS_PERIOD: state_next.prdata = {24'h000000, state_reg.period};
            EBP_OFS_TCTRL: state_next.prdata = {24'h000000, state_reg.tctrl};
            EBP_OFS_DBAND: state_next.prdata = {24'h000000, state_reg.dband};
            EBP_OFS_STEER: state_next.prdata = {28'h0000000, state_reg.steer};
            EBP_OFS_DIR: state_next.prdata = {28'h0000000, state_reg.dir};
            EBP_OFS_STATUS: state_next.prdata = {21'h000000, state_reg.running,
                                                 state_reg.tmr, fine_w};
            default: state_next.prdata = 32'h00000000;
         endcase
      end

      if (advance) begin
         // Timer: period is 4 * (period + 1) * prescale oscillator cycles.
         if (tmr_on) begin
            state_next.presc = wrap_w ? 6'h00 : state_reg.presc + 6'h01;
            if (wrap_w) begin
               state_next.tmr = boundary ? 8'h00 : state_reg.tmr + 8'h01;
            end
         end

         // Waveform starts only on a boundary, never mid-period.
         if (!(pwm_sel && tmr_on)) begin
            state_next.running = 1'b0;
         end else if (boundary) begin
            state_next.running = 1'b1;
         end

         // Shadow values reload at each boundary, and freely while stopped.
         if (!state_reg.running || boundary) begin
            state_next.duty_act = {state_reg.duty_hi,
                                   state_reg.ctrl[EBP_CTRL_DLOW_LSB +: 2]};
            state_next.db_act = state_reg.dband[6:0];
         end
      end

      // Pin use is decoded in sleep as well, so a sleeping pin stays owned
      // and keeps driving its frozen level instead of being released.
      unique case (mode_w)
         EBP_SINGLE: begin
            act = {4{active_w}};
            used = state_reg.steer;
         end
         EBP_HALF: begin
            act = {2'b00, db_b, db_a};
            used = 4'h3;
         end
         EBP_FULL_FWD: begin
            act = {active_w, 1'b0, 1'b0, state_reg.running};
            used = 4'hF;
         end
         EBP_FULL_REV: begin
            act = {1'b0, state_reg.running, active_w, 1'b0};
            used = 4'hF;
         end
      endcase
      if (HALF_BRIDGE_ONLY) begin
         used[3:2] = 2'b00;
      end
      if (advance) begin
         state_next.pin_lvl = apply_pol(act, state_reg.ctrl[EBP_CTRL_POL_AC],
                                        state_reg.ctrl[EBP_CTRL_POL_BD]);
      end

      // A zeroed control register gives every pin back at once.
      own = (state_reg.ctrl != EBP_CTRL_RST && pwm_sel) ? used : 4'h0;
      if (advance) begin
         state_next.pin_own = own;
         state_next.pin_oe = own & ~state_reg.dir;
      end else begin
         state_next.pin_own = state_reg.pin_own & own;
         state_next.pin_oe = state_reg.pin_oe & own & ~state_reg.dir;
      end
   end

   // ----------------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         state_reg <= '0;
         state_reg.ctrl <= EBP_CTRL_RST;
         state_reg.duty_hi <= EBP_DUTY_RST;
         state_reg.period <= EBP_PERIOD_RST;
         state_reg.tctrl <= EBP_TCTRL_RST;
         state_reg.dband <= EBP_DBAND_RST;
         state_reg.steer <= EBP_STEER_RST;
         state_reg.dir <= EBP_DIR_RST;
      end else if (ce_in) begin
         state_reg <= state_next;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   // One assignment drives the whole answer struct, so it has a single driver.
   assign apb_out = '{pready: ce_in && state_reg.rd_ok,
                      prdata: state_reg.prdata,
                      pslverr: ce_in && state_reg.rd_ok && !is_mapped(apb_in.paddr)};
   assign pin_level_out = ebp_pins_t'(state_reg.pin_lvl);
   assign pin_oe_out = ebp_pins_t'(state_reg.pin_oe);
   assign pin_owned_out = ebp_pins_t'(state_reg.pin_own);

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   a_zero_releases: assert property (@(posedge clk_in) disable iff (reset_in)
      (ce_in && state_reg.ctrl == EBP_CTRL_RST) |=> (state_reg.pin_oe == 4'h0 &&
                                                     state_reg.pin_own == 4'h0))
      else $error("pins still driven with control register at zero");

   a_dir_gates_oe: assert property (@(posedge clk_in) disable iff (reset_in)
      ce_in |=> ((state_reg.pin_oe & $past(state_reg.dir)) == 4'h0))
      else $error("pin driven while its direction bit was set");

   a_half_no_cd: assert property (@(posedge clk_in) disable iff (reset_in)
      HALF_BRIDGE_ONLY |-> (state_reg.pin_own[3:2] == 2'b00))
      else $error("half-bridge-only build owns output C or D");

   a_period_wrap: assert property (@(posedge clk_in) disable iff (reset_in)
      (ce_in && advance && boundary) |=> (state_reg.tmr == 8'h00 &&
                                          state_reg.presc == 6'h00))
      else $error("timer did not restart at the period boundary");

   a_start_on_edge: assert property (@(posedge clk_in) disable iff (reset_in)
      $rose(state_reg.running) |-> (state_reg.tmr == 8'h00 && state_reg.presc == 6'h00))
      else $error("waveform started away from a period boundary");

   a_duty_shadow: assert property (@(posedge clk_in) disable iff (reset_in)
      (state_reg.running && !boundary) |=> ($stable(state_reg.duty_act) &&
                                            $stable(state_reg.db_act)))
      else $error("duty or dead-band changed inside a period");

   a_fwd_levels: assert property (@(posedge clk_in) disable iff (reset_in)
      (ce_in && advance && state_reg.running && mode_w == EBP_FULL_FWD &&
       state_reg.ctrl[1:0] == 2'b00) |=> (state_reg.pin_lvl[2:0] == 3'b001))
      else $error("full forward levels on A, B, C are wrong");

   a_rev_levels: assert property (@(posedge clk_in) disable iff (reset_in)
      (ce_in && advance && state_reg.running && mode_w == EBP_FULL_REV &&
       state_reg.ctrl[1:0] == 2'b00) |=> (state_reg.pin_lvl[3] == 1'b0 &&
                                          state_reg.pin_lvl[2] == 1'b1 &&
                                          state_reg.pin_lvl[0] == 1'b0))
      else $error("full reverse levels on A, C, D are wrong");

   a_sleep_holds: assert property (@(posedge clk_in) disable iff (reset_in)
      (ce_in && sleep_in) |=> ($stable(state_reg.tmr) && $stable(state_reg.pin_lvl) &&
                               $stable(state_reg.presc)))
      else $error("timer or pins moved during sleep");

   a_half_pair: assert property (@(posedge clk_in) disable iff (reset_in)
      (ce_in && advance && state_reg.running && mode_w == EBP_HALF &&
       state_reg.db_act == 7'h00 && state_reg.ctrl[1:0] == 2'b00)
      |=> (state_reg.pin_lvl[1] == !state_reg.pin_lvl[0]))
      else $error("half-bridge outputs are not complementary");

   a_unused_free: assert property (@(posedge clk_in) disable iff (reset_in)
      (ce_in && mode_w == EBP_HALF) |=> (state_reg.pin_own[3:2] == 2'b00))
      else $error("half-bridge mode kept C or D");

   a_single_steer: assert property (@(posedge clk_in) disable iff (reset_in)
      (ce_in && !sleep_in && mode_w == EBP_SINGLE && pwm_sel &&
       state_reg.ctrl != EBP_CTRL_RST)
      |=> (state_reg.pin_own == ($past(state_reg.steer) & (HALF_BRIDGE_ONLY ? 4'h3 : 4'hF))))
      else $error("single mode owns a pin that its steering bit does not enable");

endmodule

// *** ebp_switch_model.sv ***
/*
 * Model of the switch drivers: resolves each pad and counts its high cycles.
 * Assumes the modulator's level and enable outputs on the same clock.
 */
`timescale 1ns/1ps
module ebp_switch_model
   import ebp_pkg::*;
(
   input wire logic clk_in,          // Oscillator clock.
   input wire logic clr_in,          // Clears the high counts.
   input wire ebp_pins_t level_in,   // Levels from the modulator.
   input wire ebp_pins_t oe_in,      // Drive enables from the modulator.
   output ebp_pins_t pad_out,        // Resolved pad levels.
   output logic [3:0][15:0] cnt_out  // High cycles of each pad.
);
   // An undriven pad flips every cycle, so a stale value never passes for a drive.
   initial pad_out = 4'h0;
   initial cnt_out = '0;
   always @(posedge clk_in) begin
      for (int i = 0; i < 4; i++) begin
         pad_out[i] <= oe_in[i] ? level_in[i] : ~pad_out[i];
         cnt_out[i] <= clr_in ? 16'h0000 : cnt_out[i] + 16'(pad_out[i]);
      end
   end
endmodule

// *** test_ebp_bridge_pwm.sv ***
/*
 * Testbench of the bridge modulator: APB tasks and pad-count scenarios.
 * Assumes a 50 MHz clock and the switch model; APB accesses wait on pready.
 */
`timescale 1ns/1ps
module test_ebp_bridge_pwm;
   import ebp_pkg::*;
   logic clk_in = 1'b0;
   logic reset_in = 1'b1;
   logic sleep_in = 1'b0;
   logic clr = 1'b0;
   ebp_apb_req_t req = '0;
   ebp_apb_rsp_t rsp;
   ebp_pins_t lvl, oe, own, pad;
   logic [3:0][15:0] cnt;
   logic [31:0] q;
   logic e;
   int n_mismatch = 0;
   int tests_run = 0;
   always #10 clk_in = ~clk_in;
   ebp_bridge_pwm ebp_bridge_pwm_inst (.clk_in(clk_in), .reset_in(reset_in), .ce_in(1'b1),
      .sleep_in(sleep_in), .apb_in(req), .apb_out(rsp), .pin_level_out(lvl),
      .pin_oe_out(oe), .pin_owned_out(own));
   ebp_switch_model ebp_switch_model_inst (.clk_in(clk_in), .clr_in(clr), .level_in(lvl),
      .oe_in(oe), .pad_out(pad), .cnt_out(cnt));
   task chk(input logic [63:0] got, input logic [63:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task print_verdict;
      $display("mismatches %0d of %0d comparisons", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk_in);
      req <= '{1'b1, 1'b0, wr, a, d};
      @(posedge clk_in);
      req.penable <= 1'b1;
      @(posedge clk_in);
      while (rsp.pready !== 1'b1 && k < 50) begin
         @(posedge clk_in);
         k++;
      end
      if (k == 50) n_mismatch++;
      q = rsp.prdata;
      e = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask
   // Clears the pad counts, then lets w cycles accumulate into them.
   task window(input int w);
      @(posedge clk_in);
      clr <= 1'b1;
      @(posedge clk_in);
      clr <= 1'b0;
      repeat (w) @(posedge clk_in);
      @(negedge clk_in);
   endtask
   // Programs one mode, lets it settle, then counts pad highs over a window.
   task run_case(input logic [7:0] c, d, t, input int w, input logic [63:0] exp);
      apb(1'b1, EBP_OFS_TCTRL, {24'h0, t});
      apb(1'b1, EBP_OFS_DBAND, {24'h0, d});
      apb(1'b1, EBP_OFS_CTRL, {24'h0, c});
      repeat (w) @(posedge clk_in);
      window(w);
      chk(cnt, exp);
   endtask
   initial begin
      repeat (6) @(posedge clk_in);
      reset_in <= 1'b0;
      apb(1'b0, EBP_OFS_CTRL, 0);
      chk(q, 0);
      apb(1'b0, EBP_OFS_PERIOD, 0);
      chk(q, 32'h0000_00FF);
      apb(1'b0, EBP_OFS_STEER, 0);
      chk(q, 32'h1);
      apb(1'b0, EBP_OFS_DIR, 0);
      chk({e, q}, 33'h0_0000_000F);
      apb(1'b0, 12'h020, 0);
      chk({e, q}, 33'h1_0000_0000);
      apb(1'b1, EBP_OFS_PERIOD, 32'h4);
      apb(1'b1, EBP_OFS_DUTY, 32'h2);
      apb(1'b1, EBP_OFS_TCTRL, 32'h4);
      apb(1'b1, EBP_OFS_CTRL, 32'h0C);
      repeat (30) @(posedge clk_in);
      chk({own, oe}, 8'h10);
      apb(1'b1, EBP_OFS_DIR, 32'h0);
      run_case(8'h0C, 8'h0, 8'h4, 100, 64'h0032_0032_0032_0028);
      run_case(8'h8C, 8'h1, 8'h4, 100, 64'h0032_0032_0028_0014);
      run_case(8'h8C, 8'h3, 8'h4, 100, 64'h0032_0032_0000_0000);
      run_case(8'h4C, 8'h0, 8'h4, 100, 64'h0028_0000_0000_0064);
      run_case(8'hCC, 8'h0, 8'h4, 100, 64'h0000_0064_0028_0000);
      run_case(8'h4F, 8'h0, 8'h4, 100, 64'h003C_0064_0064_0000);
      run_case(8'h0C, 8'h0, 8'h5, 400, 64'h00C8_00C8_00C8_00A0);
      // Sleep freezes the steered pin A while the unused pads keep toggling.
      @(posedge clk_in);
      sleep_in <= 1'b1;
      window(100);
      chk(cnt[3:1], 48'h0032_0032_0032);
      chk(cnt[0] == 16'h0000 || cnt[0] == 16'h0064, 1'b1);
      @(posedge clk_in);
      sleep_in <= 1'b0;
      apb(1'b1, EBP_OFS_CTRL, 32'h0);
      repeat (3) @(posedge clk_in);
      chk({own, oe}, 8'h00);
      print_verdict();
   end
   initial begin
      repeat (20000) @(posedge clk_in);
      n_mismatch++;
      print_verdict();
   end
endmodule
